// File: design/cell_balance_regs.svh
// Register offsets, fields, codes and timing constants for the balance controller.
// Assumes inclusion by bare name from the design file.
`ifndef CELL_BALANCE_REGS_SVH
`define CELL_BALANCE_REGS_SVH

// Printed indices are word indices, not byte addresses: byte address is index times four
`define CTRL_INDEX 8'h80
`define STAT_INDEX 8'h81
`define CTRL_ADDR 12'h200
`define STAT_ADDR 12'h204
`define EXPIRY_ADDR 12'h208
`define EVENT_ADDR 12'h20C
`define PINS_ADDR 12'h210

`define F_MODE 13:11
`define F_IIR 10
`define F_HOLD 9:8
`define F_DUTY 7:4
`define F_DONE_EN 3
`define F_TEMP_EN 2
`define F_MEAS 1:0
`define CTRL_WMASK 16'h3FFF
`define CTRL_RESET 16'h0000

`define MODE_OFF 3'h0
`define MODE_DISCHARGE 3'h1
`define HOLD_NONE 2'h0
`define HOLD_RUN 2'h1
`define HOLD_EXT 2'h2
`define HOLD_LATCH 2'h3
`define MEAS_ONLY 2'h2
`define MEAS_UV 2'h3
`define EXPIRY_INF 10'h3FF
`define EXPIRY_RESET 10'h3FF

`define ACT_OFF 2'h0
`define ACT_ON 2'h1
`define ACT_DONE 2'h2
`define ACT_HALT 2'h3
`define UNIT_OFF 2'h0
`define UNIT_SEC 2'h1
`define UNIT_MIN 2'h2
`define UNIT_HOUR 2'h3

`define CLK_HZ 50000000
`define SEC_CYCLES (`CLK_HZ)
`define SEC_PER_MIN 6'h3B
`define MIN_PER_HOUR 6'h3B
`define EXT_MIN_MINUTES 10'h005
`define EXT_FRACTION_SHIFT 4
`define UV_SUSPEND_SCANS 5'h10
`define PERIOD_SLOTS 4'hF
`define SCAN_DIV 8'hFF
`define DUTY_FULL 4'hF
`define SLOT_FIRST 4'h0
// Non-overlap and measurement room at full duty: plain defaults
`define NOL_CYCLES 8'h08
`define MEAS_GAP_START 8'hF0

`endif

// File: design/cell_balance_pkg.sv
// Types for the cell balance controller.
// Assumes cell_balance_regs.svh is on the include path.
package cell_balance_pkg;
    typedef enum logic [1:0] {
        run_idle = 2'b00,
        run_active = 2'b01,
        run_extend = 2'b10,
        run_latched = 2'b11
    } run_state_e;

    typedef struct packed {
        logic [2:0] mode;
        logic filter_init;
        logic [1:0] hold;
        logic [3:0] duty;
        logic done_en;
        logic temp_en;
        logic [1:0] measure;
    } control_s;

    typedef struct packed {
        logic [1:0] activity;
        logic [1:0] unit;
        logic [1:0] heartbeat;
        logic [9:0] timer;
    } status_s;

    typedef struct packed {
        logic paddr_unused;
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;
endpackage : cell_balance_pkg

// File: design/cell_balance_controller.sv
// Control and status of the cell-balancing engine, reached over APB.
// Assumes one 50 MHz clock, inputs synchronous to it, active-low async reset.
//
// The APB register port is this design's own decision.
`include "cell_balance_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cell_balance_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic temperature_alert,
    input wire logic undervoltage_exit,
    input wire logic timeout_halt_alert,
    input wire logic calibration_fault_alert,
    output logic shutdown_pin,
    output logic balance_enable,
    output logic measure_enable,
    output logic undervoltage_check_enable,
    output logic filter_init_strobe,
    output logic balance_summary_alert,
    output cell_balance_pkg::status_s balance_status
);
    import cell_balance_pkg::*;

    control_s balance_control;
    status_s status_q;
    run_state_e run_state;
    run_state_e next_run_state;
    logic [9:0] expiry_setting;
    logic [25:0] sec_count;
    logic [5:0] sub_count;
    logic [9:0] ext_count;
    logic [9:0] ext_units;
    logic [5:0] min_count;
    logic [3:0] slot;
    logic [7:0] scan_div;
    logic [4:0] uv_suspend;
    logic first_scan;
    logic completion_alert;
    logic thermal_halt_alert;

    // Bus decode
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctrl = paddr == `CTRL_ADDR;
    wire hit_stat = paddr == `STAT_ADDR;
    wire hit_exp = paddr == `EXPIRY_ADDR;
    wire hit_event = paddr == `EVENT_ADDR;
    wire hit_pins = paddr == `PINS_ADDR;
    wire mapped = hit_ctrl | hit_stat | hit_exp | hit_event | hit_pins;
    wire ctrl_wr = wr && hit_ctrl;
    wire event_clr = wr && hit_event && pwdata[0];
    wire [15:0] ctrl_wdata = pwdata[15:0] & `CTRL_WMASK;
    wire [2:0] new_mode = ctrl_wdata[`F_MODE];
    wire start = ctrl_wr && (new_mode != `MODE_OFF);
    wire stop = ctrl_wr && (new_mode == `MODE_OFF);

    // Mode decode
    wire [2:0] mode = balance_control.mode;
    wire automated = mode != `MODE_OFF;
    wire mode_discharge = mode == `MODE_DISCHARGE;
    wire mode_auto = mode[2];
    // Manual modes switch cells but never hold the shutdown pin
    wire auto_run = mode_discharge || mode_auto;
    // Unit of the mode being launched, latched into status at start
    wire new_discharge = new_mode == `MODE_DISCHARGE;
    wire [1:0] mode_unit = new_discharge ? `UNIT_HOUR :
        (new_mode[0] ? `UNIT_MIN : `UNIT_SEC);
    wire hb_running = run_state != run_idle;

    // One-second tick and unit tick
    wire sec_tick = sec_count == 26'(`SEC_CYCLES - 1);
    wire min_wrap = sub_count == `SEC_PER_MIN;
    wire hour_wrap = min_count == `MIN_PER_HOUR;
    wire unit_tick = sec_tick && ((status_q.unit == `UNIT_SEC) ||
        (status_q.unit == `UNIT_MIN && min_wrap) ||
        (status_q.unit == `UNIT_HOUR && min_wrap && hour_wrap));
    wire expired = (expiry_setting != `EXPIRY_INF) && (status_q.timer == expiry_setting);

    // Exit causes
    wire temp_exit = balance_control.temp_en && temperature_alert;
    wire halt_cause = temp_exit || timeout_halt_alert || calibration_fault_alert;
    wire uv_active = balance_control.measure == `MEAS_UV && uv_suspend == 5'h0;
    wire normal_cause = expired || (uv_active && undervoltage_exit);

    // Extension ends once both 5 minutes and 1/16 of expiry (mode units) have passed
    wire [9:0] frac = expiry_setting >> `EXT_FRACTION_SHIFT;
    wire ext_min_done = ext_count >= `EXT_MIN_MINUTES;
    wire ext_frac_done = ext_units >= frac;
    wire ext_done = ext_min_done && ext_frac_done;
    wire min_tick = sec_tick && min_wrap;

    always_comb begin
        next_run_state = run_state;
        unique case (run_state)
            run_idle: next_run_state = run_idle;
            run_active: begin
                if (halt_cause || normal_cause) begin
                    if (balance_control.hold == `HOLD_EXT) begin
                        next_run_state = run_extend;
                    end else if (balance_control.hold == `HOLD_LATCH) begin
                        next_run_state = run_latched;
                    end else begin
                        next_run_state = run_idle;
                    end
                end
            end
            run_extend: if (ext_done) next_run_state = run_idle;
            run_latched: if (balance_control.hold != `HOLD_LATCH) next_run_state = run_idle;
        endcase
        if (start) begin
            next_run_state = run_active;
        end else if (stop) begin
            next_run_state = run_idle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            balance_control <= control_s'(`CTRL_RESET);
        end else if (ctrl_wr) begin
            balance_control <= control_s'(ctrl_wdata[13:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expiry_setting <= `EXPIRY_RESET;
        end else if (wr && hit_exp) begin
            expiry_setting <= pwdata[9:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state <= run_idle;
        end else begin
            run_state <= next_run_state;
        end
    end

    // Timebase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_count <= 26'h0;
            sub_count <= 6'h0;
        end else if (start || !hb_running) begin
            sec_count <= 26'h0;
            sub_count <= 6'h0;
        end else if (sec_tick) begin
            sec_count <= 26'h0;
            sub_count <= min_wrap ? 6'h0 : sub_count + 6'h1;
        end else begin
            sec_count <= sec_count + 26'h1;
        end
    end

    // Minutes within the hour for hour-unit timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_count <= 6'h0;
        end else if (start || !hb_running) begin
            min_count <= 6'h0;
        end else if (min_tick) begin
            min_count <= hour_wrap ? 6'h0 : min_count + 6'h1;
        end
    end

    // Status: latched until stop or new start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= status_s'(16'h0000);
        end else if (stop) begin
            status_q <= status_s'(16'h0000);
        end else if (start) begin
            status_q.activity <= `ACT_ON;
            status_q.unit <= mode_unit;
            status_q.heartbeat <= 2'h0;
            status_q.timer <= 10'h000;
        end else begin
            if (hb_running && sec_tick) begin
                status_q.heartbeat <= status_q.heartbeat + 2'h1;
            end
            if (run_state == run_active) begin
                if (halt_cause) begin
                    status_q.activity <= `ACT_HALT;
                end else if (normal_cause) begin
                    status_q.activity <= `ACT_DONE;
                end else if (unit_tick) begin
                    status_q.timer <= status_q.timer + 10'h001;
                end
            end
        end
    end

    // Extension counter in minutes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_count <= 10'h0;
        end else if (run_state != run_extend) begin
            ext_count <= 10'h0;
        end else if (min_tick && !ext_min_done) begin
            ext_count <= ext_count + 10'h1;
        end
    end

    // Extension counter in mode units, saturating once the fraction is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_units <= 10'h0;
        end else if (run_state != run_extend) begin
            ext_units <= 10'h0;
        end else if (unit_tick && !ext_frac_done) begin
            ext_units <= ext_units + 10'h1;
        end
    end

    // Duty: period of 16 slots, on for code+1 slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot <= 4'h0;
            scan_div <= 8'h0;
        end else if (run_state != run_active) begin
            slot <= 4'h0;
            scan_div <= 8'h0;
        end else begin
            scan_div <= scan_div + 8'h1;
            if (scan_div == `SCAN_DIV) begin
                slot <= slot + 4'h1;
            end
        end
    end
    wire period_end = scan_div == `SCAN_DIV && slot == `PERIOD_SLOTS;
    // Full-on still leaves non-overlap, and measurement room when measuring
    wire duty_full = balance_control.duty == `DUTY_FULL;
    wire nonoverlap_time = duty_full && slot == `SLOT_FIRST && scan_div < `NOL_CYCLES;
    wire measure_gap = duty_full && balance_control.measure[1] && slot == `PERIOD_SLOTS &&
        scan_div >= `MEAS_GAP_START;
    wire duty_on = slot <= balance_control.duty &&
        !nonoverlap_time && !measure_gap;

    // Filter init and UV suspension counted in scans (one per period)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_suspend <= 5'h0;
            first_scan <= 1'b0;
        end else if (start) begin
            uv_suspend <= ctrl_wdata[`F_IIR] ? `UV_SUSPEND_SCANS : 5'h0;
            first_scan <= ctrl_wdata[`F_IIR];
        end else if (period_end) begin
            first_scan <= 1'b0;
            if (uv_suspend != 5'h0) begin
                uv_suspend <= uv_suspend - 5'h1;
            end
        end
    end

    // Sticky event flags; set wins over clear
    wire done_set = run_state == run_active && !halt_cause && normal_cause;
    wire halt_set = run_state == run_active && temp_exit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            completion_alert <= 1'b0;
            thermal_halt_alert <= 1'b0;
        end else begin
            completion_alert <= done_set || (completion_alert && !event_clr && !start);
            thermal_halt_alert <= halt_set || (thermal_halt_alert && !event_clr && !start);
        end
    end
    wire summary = (completion_alert && balance_control.done_en) ||
        thermal_halt_alert || status_q.activity == `ACT_HALT;

    wire hold_high = (balance_control.hold != `HOLD_NONE) && auto_run &&
        (run_state == run_active || run_state == run_extend ||
        run_state == run_latched);
    wire measuring = balance_control.measure[1];

    wire [9:0] shown_timer = (run_state == run_extend || run_state == run_latched) ?
        expiry_setting : status_q.timer;
    wire [15:0] stat_word = {status_q.activity, status_q.unit, status_q.heartbeat, shown_timer};
    wire [31:0] read_mux = hit_ctrl ? {16'h0, status_q.activity, 14'(balance_control)} :
        hit_stat ? {16'h0, stat_word} :
        hit_exp ? {22'h0, expiry_setting} :
        hit_event ? {30'h0, thermal_halt_alert, completion_alert} :
        hit_pins ? {28'h0, shutdown_pin, balance_enable, measure_enable, undervoltage_check_enable} :
        32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `CTRL_ADDR || paddr == `STAT_ADDR ||
                paddr == `EXPIRY_ADDR || paddr == `EVENT_ADDR || paddr == `PINS_ADDR);
            prdata <= (psel && !penable && !pwrite) ? read_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_pin <= 1'b0;
            balance_enable <= 1'b0;
            measure_enable <= 1'b0;
            undervoltage_check_enable <= 1'b0;
            filter_init_strobe <= 1'b0;
            balance_summary_alert <= 1'b0;
            balance_status <= status_s'(16'h0000);
        end else begin
            shutdown_pin <= hold_high;
            balance_enable <= run_state == run_active && automated && duty_on;
            measure_enable <= run_state == run_active && measuring;
            undervoltage_check_enable <= run_state == run_active && uv_active;
            filter_init_strobe <= first_scan && run_state == run_active;
            balance_summary_alert <= summary;
            balance_status <= status_s'(stat_word);
        end
    end

    wire unused_ok = &{1'b0, mapped, `CTRL_INDEX, `STAT_INDEX};
endmodule // cell_balance_controller

`default_nettype wire

// File: testbench/cell_balance_props.sv
// Checker for the balance controller: APB timing, status and control outputs.
// Assumes binding to cell_balance_controller, control word at byte 0x200.
`timescale 1ns/1ps
`default_nettype none
module cell_balance_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic temperature_alert,
    input wire logic timeout_halt_alert,
    input wire logic calibration_fault_alert,
    input wire logic shutdown_pin,
    input wire logic measure_enable,
    input wire logic undervoltage_check_enable,
    input wire cell_balance_pkg::status_s balance_status
);
    import cell_balance_pkg::*;
    logic [15:0] ctrl_q;
    logic [1:0] quiet;
    wire wr_ctrl = psel && penable && pwrite && pready && paddr == 12'h200;
    wire settled = quiet == 2'h3;
    wire no_fault = !timeout_halt_alert && !calibration_fault_alert;
    function automatic logic [1:0] unit_of(input logic [2:0] m);
        return m == 3'h0 ? 2'h0 : m == 3'h1 ? 2'h3 : m[0] ? 2'h2 : 2'h1;
    endfunction
    // Last control word written, and cycles since
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 16'h0000;
            quiet <= 2'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata[15:0];
            quiet <= wr_ctrl ? 2'h0 : (settled ? quiet : quiet + 2'h1);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_unit_follows_mode: assert property (wr_ctrl |=> ##[1:3]
        balance_status.unit == unit_of(ctrl_q[13:11])) else $error("unit wrong");
    a_start_active_zero: assert property (wr_ctrl && pwdata[13:11] != 3'h0
        && !temperature_alert && no_fault |=> ##[1:3] balance_status.activity == 2'h1
        && balance_status.timer == 10'h000) else $error("start not active at zero");
    a_stop_clears_status: assert property (wr_ctrl && pwdata[13:11] == 3'h0
        |=> ##[1:3] balance_status == 16'h0000) else $error("status not cleared");
    a_thermal_halts: assert property (settled && ctrl_q[2] && temperature_alert
        && balance_status.activity == 2'h1 |-> ##[1:8] balance_status.activity == 2'h3)
        else $error("no thermal halt");
    a_thermal_ignored: assert property (settled && !ctrl_q[2] && no_fault && !wr_ctrl
        && balance_status.activity == 2'h1 |=> balance_status.activity != 2'h3)
        else $error("halt without enable");
    a_measure_off: assert property (settled && !ctrl_q[1]
        |-> !measure_enable && !undervoltage_check_enable) else $error("measure while off");
    a_uv_check_off: assert property (settled && ctrl_q[1:0] == 2'h2
        |-> !undervoltage_check_enable) else $error("uv check while off");
    a_hold_none: assert property (settled && ctrl_q[9:8] == 2'h0 |-> !shutdown_pin)
        else $error("pin held with no hold");
    a_manual_no_hold: assert property (settled && ctrl_q[13:12] == 2'h1 |-> !shutdown_pin)
        else $error("pin held in manual mode");
    a_hold_latched: assert property (settled && !wr_ctrl && ctrl_q[9:8] == 2'h3
        && shutdown_pin |=> shutdown_pin) else $error("latched hold dropped");
    c_halted: cover property (balance_status.activity == 2'h3);
    c_completed: cover property (balance_status.activity == 2'h2);
    c_uv_checking: cover property (undervoltage_check_enable && shutdown_pin);
endmodule // cell_balance_props
bind cell_balance_controller cell_balance_props u_cell_balance_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .temperature_alert(temperature_alert),
    .timeout_halt_alert(timeout_halt_alert), .calibration_fault_alert(calibration_fault_alert),
    .shutdown_pin(shutdown_pin), .measure_enable(measure_enable),
    .undervoltage_check_enable(undervoltage_check_enable), .balance_status(balance_status));
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the balance controller over APB.
// Assumes the checker is bound; zero-wait slave, control 0x200, status 0x204, events 0x20C.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cell_balance_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, c;
    logic pready, pslverr, shutdown_pin, balance_enable, measure_enable, uv_en, init_strobe, summary;
    logic temperature_alert = 1'b0, undervoltage_exit = 1'b0;
    logic timeout_halt_alert = 1'b0, calibration_fault_alert = 1'b0;
    logic [1:0] ms;
    status_s balance_status;
    int mismatches = 0, n_checks = 0, hi;
    int dt[4] = '{0, 5, 14, 15};
    always #10 pclk = ~pclk;
    cell_balance_controller u_cell_balance_controller (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .temperature_alert(temperature_alert),
        .undervoltage_exit(undervoltage_exit), .timeout_halt_alert(timeout_halt_alert),
        .calibration_fault_alert(calibration_fault_alert), .shutdown_pin(shutdown_pin),
        .balance_enable(balance_enable), .measure_enable(measure_enable),
        .undervoltage_check_enable(uv_en), .filter_init_strobe(init_strobe),
        .balance_summary_alert(summary), .balance_status(balance_status));
    function automatic logic [1:0] unit_of(input logic [2:0] m);
        return m == 3'h0 ? 2'h0 : m == 3'h1 ? 2'h3 : m[0] ? 2'h2 : 2'h1;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        check(pready, 1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic start(input logic [31:0] d);
        apb(1'b1, 12'h200, d);
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_act(input logic [1:0] a, input int n);
        for (int i = 0; i < n && balance_status.activity !== a; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1900000;
        mismatches++;
        final_report;
    end
    initial begin
        void'($urandom(9));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h200, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h204, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h3FC, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        for (int m = 1; m < 8; m++) begin
            ms = 2'($urandom_range(3));
            c = {18'h0, m[2:0], 1'b0, 2'h1, 4'($urandom_range(15)), 2'b00, ms};
            start(c);
            apb(1'b0, 12'h204, 32'h0);
            check(rd, {16'h0, 2'h1, unit_of(m[2:0]), 12'h000});
            apb(1'b0, 12'h200, 32'h0);
            check(rd, {16'h0, 2'h1, c[13:0]});
            check(shutdown_pin, m != 2 && m != 3);
            check(measure_enable, ms[1]);
            check(uv_en, ms == 2'h3);
            check(balance_status, {2'h1, unit_of(m[2:0]), 12'h000});
        end
        start(32'h0);
        check(balance_status, 32'h0);
        check(shutdown_pin, 1'b0);
        start(32'h2300);
        temperature_alert <= 1'b1;
        repeat (50) @(posedge pclk);
        check(balance_status.activity, 2'h1);
        temperature_alert <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            start(32'h2304);
            check(balance_status.activity, 2'h1);
            {calibration_fault_alert, timeout_halt_alert, temperature_alert} <= 3'h1 << k;
            wait_act(2'h3, 100);
            check(balance_status.activity, 2'h3);
            check(shutdown_pin, 1'b1);
            {calibration_fault_alert, timeout_halt_alert, temperature_alert} <= 3'h0;
            @(posedge pclk);
        end
        start(32'h0);
        check(shutdown_pin, 1'b0);
        foreach (dt[j]) begin
            start(32'h1000 | (dt[j] << 4));
            hi = 0;
            repeat (4096) begin
                @(posedge pclk);
                hi += balance_enable;
            end
            check(hi <= 256 * (dt[j] + 1) && hi > 256 * dt[j], 1'b1);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h20C, 32'h1);
            start(32'h2203 | (k << 3));
            undervoltage_exit <= 1'b1;
            wait_act(2'h2, 20000);
            check(balance_status.activity, 2'h2);
            check(summary, k);
            check(shutdown_pin, 1'b1);
            check(balance_status.timer, 10'h3FF);
            repeat (20) @(posedge pclk);
            check(balance_status.activity, 2'h2);
            undervoltage_exit <= 1'b0;
        end
        start(32'h2403);
        for (int i = 0; i < 10000 && init_strobe !== 1'b1; i++) @(posedge pclk);
        check(init_strobe, 1'b1);
        check(uv_en, 1'b0);
        final_report;
    end
endmodule // testbench
`default_nettype wire
